// ---- pkg/port_pkg.sv ----
package port_pkg;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0] PORT_DATA_OFS = 8'h00;
   localparam logic [7:0] PORT_DIR_OFS = 8'h04;
   localparam logic [7:0] ANALOG_CFG_OFS = 8'h08;
   localparam logic [7:0] CHAN_SEL_OFS = 8'h0C;
   localparam logic [7:0] CLOCK_MODE_OFS = 8'h10;
   localparam logic [7:0] BIT_OP_OFS = 8'h14;
   localparam logic [7:0] STATUS_OFS = 8'h18;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] DIR_RST = 8'hFF;
   localparam logic [7:0] LATCH_RST = 8'h00;
   localparam logic [7:0] ANALOG_RST = 8'hFF;
   localparam logic [2:0] CHAN_RST = 3'h0;
   localparam logic [1:0] CLOCK_MODE_RST = 2'h0;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int BIT_OP_IDX_LSB = 0;
   localparam int BIT_OP_VAL_POS = 3;
   localparam int CLK_MAIN_POS = 0;
   localparam int CLK_SUB_POS = 1;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      rmw_idle = 2'b00,
      rmw_read = 2'b01,
      rmw_write = 2'b11
   } rmw_state_t;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } pin_drive_t;

endpackage

// ---- rtl/port_pin_function_control.sv ----
`timescale 1ns/1ps
module port_pin_function_control #(
   parameter int WIDTH = 8,
   parameter bit DEBUG_PRESENT = 1'b1
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Port pins
   input wire logic [WIDTH-1:0] pin_in,
   output port_pkg::pin_drive_t pin_drive,
   // Analog side
   output logic [WIDTH-1:0] analog_input_pin,
   output logic [2:0] converter_channel_select,
   output logic convert_enable,
   // Clock and debug side
   output logic main_osc_enable,
   output logic sub_osc_enable,
   input wire logic debug_active,
   output logic [3:0] debug_mode_pin
);

   // ****************************************
   // State
   // ****************************************
   logic [WIDTH-1:0] dir_r, dir_nxt;
   logic [WIDTH-1:0] latch_r, latch_nxt;
   logic [WIDTH-1:0] analog_r, analog_nxt;
   logic [2:0] chan_r, chan_nxt;
   logic [1:0] clkmode_r, clkmode_nxt;
   logic [WIDTH-1:0] sync1_r, sync2_r;
   logic [7:0] waddr_r, waddr_nxt;
   logic wpend_r, wpend_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [31:0] read_word;
   port_pkg::rmw_state_t rmw_r, rmw_nxt;
   logic [WIDTH-1:0] rmw_byte_r, rmw_byte_nxt;
   logic [3:0] rmw_op_r, rmw_op_nxt;
   logic [WIDTH-1:0] port_view;
   logic [WIDTH-1:0] conflict;
   logic accept;

   // ****************************************
   // Pin read path
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= pin_in;
         sync2_r <= sync1_r;
      end
   end

   // Input bits show the pin, output bits show the latch.
   assign port_view = (dir_r & sync2_r) | (~dir_r & latch_r);

   // Analog selection with output mode is prohibited; the driver is kept off and flagged.
   assign conflict = analog_r & ~dir_r;

   // ****************************************
   // Pin drive
   // ****************************************
   always_comb begin
      pin_drive.out = latch_r;
      pin_drive.oe = ~dir_r & ~analog_r;
      // Oscillator pins are handed to the clock block regardless of port setup.
      if (clkmode_r[port_pkg::CLK_MAIN_POS]) begin
         pin_drive.oe[WIDTH-1 -: 2] = 2'b00;
      end
      if (clkmode_r[port_pkg::CLK_SUB_POS]) begin
         pin_drive.oe[WIDTH-3 -: 2] = 2'b00;
      end
   end

   assign analog_input_pin = analog_r & dir_r;
   assign converter_channel_select = chan_r;
   assign convert_enable = analog_r[chan_r] & dir_r[chan_r];
   assign main_osc_enable = clkmode_r[port_pkg::CLK_MAIN_POS];
   assign sub_osc_enable = clkmode_r[port_pkg::CLK_SUB_POS];
   // Debug straps: two main oscillator pins and two low port pins.
   assign debug_mode_pin = (DEBUG_PRESENT && debug_active) ?
      {sync2_r[WIDTH-1], sync2_r[WIDTH-2], sync2_r[2], sync2_r[1]} : 4'h0;

   // ****************************************
   // Bus and register next state
   // ****************************************
   // Requests are taken on hsel, hready and htrans[1] alone; the bit operation state does not gate them.
   assign accept = hsel && hready && htrans[1];
   // A stall with no data phase open only holds off the next address phase.
   assign hreadyout = (rmw_r == port_pkg::rmw_idle);
   assign hresp = 1'b0;
   assign hrdata = rdata_r;

   // ****************************************
   // Read data
   // ****************************************
   // The word is captured as the address is taken, so it stands for the whole data phase.
   // A read right behind a write to the same register still returns the old value.
   always_comb begin
      unique case (haddr[7:0])
         port_pkg::PORT_DATA_OFS: read_word = 32'(port_view);
         port_pkg::PORT_DIR_OFS: read_word = 32'(dir_r);
         port_pkg::ANALOG_CFG_OFS: read_word = 32'(analog_r);
         port_pkg::CHAN_SEL_OFS: read_word = 32'(chan_r);
         port_pkg::CLOCK_MODE_OFS: read_word = 32'(clkmode_r);
         port_pkg::STATUS_OFS: read_word = 32'(conflict);
         default: read_word = 32'h0000_0000;
      endcase
   end

   always_comb begin
      dir_nxt = dir_r;
      latch_nxt = latch_r;
      analog_nxt = analog_r;
      chan_nxt = chan_r;
      clkmode_nxt = clkmode_r;
      waddr_nxt = waddr_r;
      wpend_nxt = 1'b0;
      rdata_nxt = rdata_r;
      rmw_nxt = rmw_r;
      rmw_byte_nxt = rmw_byte_r;
      rmw_op_nxt = rmw_op_r;
      if (accept) begin
         wpend_nxt = hwrite;
         waddr_nxt = haddr[7:0];
      end
      if (accept && !hwrite) begin
         rdata_nxt = read_word;
      end
      // Write data arrives in the data phase, one cycle after its address was taken.
      if (wpend_r) begin
         unique case (waddr_r)
            port_pkg::PORT_DATA_OFS: latch_nxt = hwdata[WIDTH-1:0];
            port_pkg::PORT_DIR_OFS: dir_nxt = hwdata[WIDTH-1:0];
            port_pkg::ANALOG_CFG_OFS: analog_nxt = hwdata[WIDTH-1:0];
            port_pkg::CHAN_SEL_OFS: chan_nxt = hwdata[2:0];
            port_pkg::CLOCK_MODE_OFS: clkmode_nxt = hwdata[1:0];
            port_pkg::BIT_OP_OFS: begin
               rmw_op_nxt = hwdata[3:0];
               rmw_nxt = port_pkg::rmw_read;
            end
            default: begin
            end
         endcase
      end
      // Bit operation stalls the bus for its read and write-back cycles.
      unique case (rmw_r)
         port_pkg::rmw_idle: begin
         end
         port_pkg::rmw_read: begin
            // Input bits copy their synchronised pin levels into the byte, as a byte read would.
            rmw_byte_nxt = port_view;
            rmw_nxt = port_pkg::rmw_write;
         end
         port_pkg::rmw_write: begin
            latch_nxt = rmw_byte_r;
            latch_nxt[rmw_op_r[2:0]] = rmw_op_r[port_pkg::BIT_OP_VAL_POS];
            rmw_nxt = port_pkg::rmw_idle;
         end
         default: rmw_nxt = port_pkg::rmw_idle;
      endcase
   end

   // ****************************************
   // Register update
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dir_r <= port_pkg::DIR_RST;
         latch_r <= port_pkg::LATCH_RST;
         analog_r <= port_pkg::ANALOG_RST;
         chan_r <= port_pkg::CHAN_RST;
         clkmode_r <= port_pkg::CLOCK_MODE_RST;
         waddr_r <= 8'h00;
         wpend_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rmw_r <= port_pkg::rmw_idle;
         rmw_byte_r <= '0;
         rmw_op_r <= 4'h0;
      end else begin
         dir_r <= dir_nxt;
         latch_r <= latch_nxt;
         analog_r <= analog_nxt;
         chan_r <= chan_nxt;
         clkmode_r <= clkmode_nxt;
         waddr_r <= waddr_nxt;
         wpend_r <= wpend_nxt;
         rdata_r <= rdata_nxt;
         rmw_r <= rmw_nxt;
         rmw_byte_r <= rmw_byte_nxt;
         rmw_op_r <= rmw_op_nxt;
      end
   end

endmodule

// ---- sim/port_props.sv ----
`timescale 1ns/1ps
module port_props #(parameter int WIDTH = 8) (
   // Bus
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // Pins and side outputs
   input wire logic [WIDTH-1:0] pin_in,
   input wire port_pkg::pin_drive_t pin_drive,
   input wire logic [WIDTH-1:0] analog_input_pin,
   input wire logic [2:0] converter_channel_select,
   input wire logic convert_enable,
   input wire logic main_osc_enable,
   input wire logic sub_osc_enable,
   input wire logic debug_active,
   input wire logic [3:0] debug_mode_pin
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence bitop_req;
      hsel && hready && htrans[1] && hwrite && haddr[7:0] == port_pkg::BIT_OP_OFS;
   endsequence
   sequence rmw_stall;
      hreadyout ##1 !hreadyout [*2] ##1 hreadyout;
   endsequence
   chk_reset_input: assert property ($rose(hresetn) |-> pin_drive.oe == 8'h00)
      else $error("driver enabled right after reset");
   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("error response seen");
   chk_main_osc: assert property (main_osc_enable |-> pin_drive.oe[7:6] == 2'h0)
      else $error("main oscillator pins still driven");
   chk_sub_osc: assert property (sub_osc_enable |-> pin_drive.oe[5:4] == 2'h0)
      else $error("sub oscillator pins still driven");
   chk_analog_undriven: assert property ((pin_drive.oe & analog_input_pin) == 8'h00)
      else $error("analog pin driven");
   chk_convert_sel: assert property (convert_enable |-> analog_input_pin[converter_channel_select])
      else $error("converted channel is not an analog input");
   chk_debug_idle: assert property (!debug_active |-> debug_mode_pin == 4'h0)
      else $error("debug pins active while debug off");
   chk_debug_sync: assert property ((debug_active && $stable(pin_in)) [*3] |->
      debug_mode_pin == {pin_in[7], pin_in[6], pin_in[2], pin_in[1]})
      else $error("debug pins do not follow synchronised levels");
   chk_rmw_stall: assert property (bitop_req |=> rmw_stall)
      else $error("bit operation stall shape wrong");
endmodule
bind port_pin_function_control port_props #(.WIDTH(WIDTH)) u_props (.hclk(hclk),
   .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
   .pin_drive(pin_drive), .analog_input_pin(analog_input_pin),
   .converter_channel_select(converter_channel_select), .convert_enable(convert_enable),
   .main_osc_enable(main_osc_enable), .sub_osc_enable(sub_osc_enable),
   .debug_active(debug_active), .debug_mode_pin(debug_mode_pin));

// ---- sim/pin_model.sv ----
`timescale 1ns/1ps
module pin_model (
   // Pads
   input wire port_pkg::pin_drive_t pin_drive,
   input wire logic [7:0] ext,
   output logic [7:0] pin_in
);
   // An undriven pad shows only what the outside world applies to it.
   assign pin_in = (pin_drive.out & pin_drive.oe) | (ext & ~pin_drive.oe);
endmodule

// ---- sim/port_pin_function_control_test.sv ----
`timescale 1ns/1ps
module port_pin_function_control_test;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, cen, mosc, sosc;
   logic dbg = 0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
   logic [7:0] ext = 8'hFF, pin_in, ana;
   logic [2:0] chan;
   logic [3:0] dpin;
   port_pkg::pin_drive_t drv;
   int bad_count = 0, checks = 0;
   always #5 hclk = ~hclk;
   port_pin_function_control u_port_pin_function_control (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .pin_in(pin_in), .pin_drive(drv), .analog_input_pin(ana),
      .converter_channel_select(chan), .convert_enable(cen), .main_osc_enable(mosc),
      .sub_osc_enable(sosc), .debug_active(dbg), .debug_mode_pin(dpin));
   pin_model u_pin_model (.pin_drive(drv), .ext(ext), .pin_in(pin_in));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // One idle edge after each transfer lets register writes reach the outputs before compares.
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
      @(posedge hclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(q, {24'h0, e});
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #100000;
      bad_count++;
      results();
   end
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      rd(port_pkg::PORT_DIR_OFS, 8'hFF);
      rd(port_pkg::ANALOG_CFG_OFS, 8'hFF);
      chk({16'h0, drv.oe, drv.out}, 32'h0);
      $display("reset test done");
      bus(1'b1, port_pkg::ANALOG_CFG_OFS, 8'h00);
      bus(1'b1, port_pkg::PORT_DATA_OFS, 8'h5A);
      bus(1'b1, port_pkg::PORT_DIR_OFS, 8'hF0);
      chk({16'h0, drv.oe, drv.out}, 32'h0F5A);
      rd(port_pkg::PORT_DATA_OFS, 8'hFA);
      $display("direction test done");
      bus(1'b1, port_pkg::PORT_DATA_OFS, 8'h00);
      bus(1'b1, port_pkg::PORT_DIR_OFS, 8'hFE);
      bus(1'b1, port_pkg::BIT_OP_OFS, 8'h08);
      bus(1'b1, port_pkg::PORT_DIR_OFS, 8'h00);
      chk({24'h0, drv.out}, 32'hFF);
      bus(1'b1, port_pkg::PORT_DATA_OFS, 8'h01);
      chk({16'h0, drv.oe, drv.out}, 32'hFF01);
      $display("bit operation test done");
      bus(1'b1, port_pkg::CLOCK_MODE_OFS, 8'h03);
      chk({29'h0, mosc, sosc, 1'b0}, 32'h6);
      chk({24'h0, drv.oe}, 32'h0F);
      bus(1'b1, port_pkg::CLOCK_MODE_OFS, 8'h00);
      $display("oscillator test done");
      bus(1'b1, port_pkg::ANALOG_CFG_OFS, 8'h0F);
      rd(port_pkg::STATUS_OFS, 8'h0F);
      chk({24'h0, drv.oe}, 32'hF0);
      bus(1'b1, port_pkg::PORT_DIR_OFS, 8'hFF);
      bus(1'b1, port_pkg::ANALOG_CFG_OFS, 8'hFF);
      bus(1'b1, port_pkg::CHAN_SEL_OFS, 8'h03);
      chk({20'h0, cen, chan, ana}, 32'hBFF);
      bus(1'b1, port_pkg::ANALOG_CFG_OFS, 8'h00);
      chk({31'h0, cen}, 32'h0);
      $display("analog test done");
      ext <= 8'h86;
      dbg <= 1'b1;
      repeat (4) @(posedge hclk);
      chk({28'h0, dpin}, 32'hB);
      rd(8'h1C, 8'h00);
      $display("debug and unmapped test done");
      results();
   end
endmodule
